// >>> core/dsi_pkg.sv
// Constants for the dual-channel serial interrupt daisy chain block.
// Assumes a single system clock and a synchronous active-high reset.
//
// Summary of operation
// R1: Polling needs master enable and DMA enable cleared
// R2: Channel B vector read always carries status
// R3: Channel B vector status tracks live pending
// R4: Vector read value frozen during the read
// R5: Clearing condition clears pending, request drops
// R6: Acknowledge sets under-service of winning source
// R7: No-vector set floats bus during acknowledge
// R8: Status-in-vector replaces three vector bits
// R9: Status placed bits 1-3 or 4-6
// R10: Status code table, MSB at V3 or V4
// R11: Only reset-highest command or reset clears service
// R12: Receive interrupt on character or special condition
// R13: Transmit pending only on full-to-empty transition
// R14: External status causes individually maskable
// R15: No pending without enable; enables write-only
// R16: Pending readable only channel A; service hidden
// R17: Fixed priority A rx,tx,ext then B
// R18: Service masks lower; acknowledge gates pending
// R19: Master enable clear acts as priority-in low; priority-out ignores master enable
// R20: Request only when enabled, pending, unmasked, idle
// R21: Acknowledge: priority-out low if pending or service
// R22: Disable-lower-chain forces priority-out low
`default_nettype none

package dsi_pkg;

	// ****************************************************************
	// Register offsets
	// ****************************************************************
	localparam logic [3:0] OFF_COMMAND_A     = 4'h0;
	localparam logic [3:0] OFF_IRQ_DMA_A     = 4'h1;
	localparam logic [3:0] OFF_VECTOR_BASE   = 4'h2;
	localparam logic [3:0] OFF_MASTER_CTRL   = 4'h3;
	localparam logic [3:0] OFF_EXT_EN_A      = 4'h4;
	localparam logic [3:0] OFF_COMMAND_B     = 4'h5;
	localparam logic [3:0] OFF_IRQ_DMA_B     = 4'h6;
	localparam logic [3:0] OFF_EXT_EN_B      = 4'h7;
	localparam logic [3:0] OFF_PRIMARY_A     = 4'h8;
	localparam logic [3:0] OFF_PRIMARY_B     = 4'h9;
	localparam logic [3:0] OFF_VECTOR_A      = 4'ha;
	localparam logic [3:0] OFF_VECTOR_B      = 4'hb;
	localparam logic [3:0] OFF_PENDING_A     = 4'hc;
	localparam logic [3:0] OFF_SPECIAL_RX_A  = 4'hd;
	localparam logic [3:0] OFF_SPECIAL_RX_B  = 4'he;

	// ****************************************************************
	// Field positions
	// ****************************************************************
	// Master control
	localparam int MC_VIS    = 0;
	localparam int MC_NV     = 1;
	localparam int MC_DLC    = 2;
	localparam int MC_MIE    = 3;
	localparam int MC_STHI   = 4;
	localparam int MC_SWRST  = 7;
	// Irq/dma mode
	localparam int ID_EXT_IE = 0;
	localparam int ID_TX_IE  = 1;
	localparam int ID_PAR_SP = 2;
	localparam int ID_RX_IE  = 3;
	localparam int ID_DMA_EN = 7;
	// Command codes
	localparam logic [7:0] CMD_RST_EXT     = 8'h10;
	localparam logic [7:0] CMD_RST_TX_IP   = 8'h28;
	localparam logic [7:0] CMD_ERR_RESET   = 8'h30;
	localparam logic [7:0] CMD_RST_HI_IUS  = 8'h38;
	// Source indices, highest priority first
	localparam int SRC_A_RX  = 0;
	localparam int SRC_A_TX  = 1;
	localparam int SRC_A_EXT = 2;
	localparam int SRC_B_RX  = 3;
	localparam int SRC_B_TX  = 4;
	localparam int SRC_B_EXT = 5;
	localparam int NUM_SRC   = 6;

	// ****************************************************************
	// Reset values and timing
	// ****************************************************************
	localparam logic [7:0] MC_RESET       = 8'hc0;
	localparam logic [7:0] EXT_EN_RESET   = 8'hf8;
	localparam int         CLK_HZ         = 20_000_000;
	localparam int         SETTLE_NS      = 250;
	localparam int         SETTLE_CYC     =
		(SETTLE_NS * (CLK_HZ / 1_000_000) + 999) / 1000;

endpackage : dsi_pkg

`default_nettype wire

// >>> core/dsi_src_cell.sv
// One interrupt source cell: pending and under-service bits of one source.
// Assumes the enclosing chain supplies priority and acknowledge qualifiers.
`default_nettype none

module dsi_src_cell
(
	input  wire logic sys_clk_i,   // System clock
	input  wire logic srst_i,      // Sync reset
	input  wire logic enable_i,    // Source enable
	input  wire logic set_i,       // Condition event
	input  wire logic clr_i,       // Condition removed
	input  wire logic grant_i,     // Acknowledge won
	input  wire logic svc_clr_i,   // Reset highest service
	output logic      pending_o,   // Pending bit
	output logic      service_o    // Under-service bit
);

	logic pend_r;
	logic pend_nxt;
	logic svc_r;
	logic svc_nxt;

	always_comb
	begin
		// Set wins over a same-cycle clear
		pend_nxt = pend_r;
		if (clr_i)
			pend_nxt = 1'b0;
		if (set_i && enable_i)   // R15
			pend_nxt = 1'b1;
		if (!enable_i)
			pend_nxt = 1'b0;     // R15
		svc_nxt = svc_r;
		if (svc_clr_i)
			svc_nxt = 1'b0;      // R11
		if (grant_i)
			svc_nxt = 1'b1;      // R6
	end

	always_ff @(posedge sys_clk_i)
	begin
		if (srst_i)
		begin
			pend_r <= 1'b0;
			svc_r  <= 1'b0;
		end
		else
		begin
			pend_r <= pend_nxt;
			svc_r  <= svc_nxt;
		end
	end

	assign pending_o = pend_r;
	assign service_o = svc_r;

endmodule : dsi_src_cell

`default_nettype wire

// >>> core/dsi_irq_chain.sv
// Interrupt daisy chain of a two-channel serial controller: six sources,
// pending and under-service tracking, request, acknowledge and vector.
// Assumes source events arrive on the system clock; priority-in and the
// acknowledge pin are asynchronous and are synchronised here.
`default_nettype none

module dsi_irq_chain
	import dsi_pkg::*;
#(
	parameter int SETTLE = dsi_pkg::SETTLE_CYC
)
(
	input  wire logic        sys_clk_i,      // System clock
	input  wire logic        srst_i,         // Sync reset
	input  wire logic [3:0]  addr_i,         // Register address
	input  wire logic [7:0]  wdata_i,        // Write data
	input  wire logic        wr_i,           // Write strobe
	input  wire logic        rd_i,           // Read strobe
	output logic      [7:0]  rdata_o,        // Read data
	input  wire logic [1:0]  rx_char_i,      // Char available {B,A}
	input  wire logic [1:0]  rx_special_i,   // Special condition {B,A}
	input  wire logic [1:0]  rx_parity_i,    // Parity error {B,A}
	input  wire logic [1:0]  rx_pop_i,       // Char removed {B,A}
	input  wire logic [1:0]  tx_empty_i,     // Tx buffer empty {B,A}
	input  wire logic [1:0]  tx_load_i,      // Tx char written {B,A}
	input  wire logic [5:0]  ext_stat_a_i,   // Ext status causes A
	input  wire logic [5:0]  ext_stat_b_i,   // Ext status causes B
	input  wire logic        priority_in_i,  // Chain priority in pin
	input  wire logic        irq_acknowledge_n_i, // Acknowledge pin
	output logic             priority_out_o, // Chain priority out
	output logic             irq_req_o,      // Request pin output
	output logic             irq_req_oe_n_o, // Low while pulling low
	output logic      [7:0]  ack_data_o,     // Acknowledge vector
	output logic             ack_data_oe_n_o,// Low while driving vector
	output logic      [1:0]  error_reset_o   // Error reset pulse {B,A}
);

	if (SETTLE < 1 || SETTLE > 256)
		$error("SETTLE must be 1 to 256 cycles");

	// ****************************************************************
	// Pin synchronisers
	// ****************************************************************
	logic [2:0] pin_r;
	logic [2:0] pin_nxt;
	logic [2:0] ack_r;
	logic [2:0] ack_nxt;
	logic       pin_ok_r;
	logic       pin_ok_nxt;
	logic       ack_on_r;
	logic       ack_on_nxt;

	always_comb
	begin
		pin_nxt    = {pin_r[1:0], priority_in_i};
		ack_nxt    = {ack_r[1:0], ~irq_acknowledge_n_i};
		pin_ok_nxt = (pin_r[1] == pin_r[2]) ? pin_r[2] : pin_ok_r;
		ack_on_nxt = (ack_r[1] == ack_r[2]) ? ack_r[2] : ack_on_r;
	end

	always_ff @(posedge sys_clk_i)
	begin
		if (srst_i)
		begin
			pin_r    <= 3'h0;
			ack_r    <= 3'h0;
			pin_ok_r <= 1'b0;
			ack_on_r <= 1'b0;
		end
		else
		begin
			pin_r    <= pin_nxt;
			ack_r    <= ack_nxt;
			pin_ok_r <= pin_ok_nxt;
			ack_on_r <= ack_on_nxt;
		end
	end

	// ****************************************************************
	// Control registers
	// ****************************************************************
	logic [7:0] mc_r,   mc_nxt;
	logic [7:0] vbase_r, vbase_nxt;
	logic [7:0] mode_a_r, mode_a_nxt;
	logic [7:0] mode_b_r, mode_b_nxt;
	logic [7:0] exten_a_r, exten_a_nxt;
	logic [7:0] exten_b_r, exten_b_nxt;
	logic       sw_rst_r, sw_rst_nxt;
	logic       rst;

	assign rst = srst_i | sw_rst_r;

	always_comb
	begin
		mc_nxt      = mc_r;
		vbase_nxt   = vbase_r;
		mode_a_nxt  = mode_a_r;
		mode_b_nxt  = mode_b_r;
		exten_a_nxt = exten_a_r;
		exten_b_nxt = exten_b_r;
		sw_rst_nxt  = 1'b0;
		if (wr_i)
		begin
			case (addr_i)
				OFF_MASTER_CTRL:
				begin
					mc_nxt = {1'b0, wdata_i[6:0]};
					sw_rst_nxt = wdata_i[MC_SWRST];
				end
				OFF_VECTOR_BASE: vbase_nxt   = wdata_i;
				OFF_IRQ_DMA_A:   mode_a_nxt  = wdata_i;
				OFF_IRQ_DMA_B:   mode_b_nxt  = wdata_i;
				OFF_EXT_EN_A:    exten_a_nxt = wdata_i; // R14
				OFF_EXT_EN_B:    exten_b_nxt = wdata_i; // R14
				default:         mc_nxt      = mc_r;
			endcase
		end
	end

	always_ff @(posedge sys_clk_i)
	begin
		if (srst_i)
		begin
			mc_r      <= MC_RESET;
			vbase_r   <= 8'h00;
			sw_rst_r  <= 1'b0;
		end
		else
		begin
			mc_r      <= mc_nxt;
			vbase_r   <= vbase_nxt;
			sw_rst_r  <= sw_rst_nxt;
		end
		if (rst)
		begin
			mode_a_r  <= 8'h00;
			mode_b_r  <= 8'h00;
			exten_a_r <= EXT_EN_RESET;
			exten_b_r <= EXT_EN_RESET;
		end
		else
		begin
			mode_a_r  <= mode_a_nxt;
			mode_b_r  <= mode_b_nxt;
			exten_a_r <= exten_a_nxt;
			exten_b_r <= exten_b_nxt;
		end
	end

	// ****************************************************************
	// Source events
	// ****************************************************************
	logic [NUM_SRC-1:0] src_en, src_set, src_clr;
	logic [1:0]         tx_full_r, tx_full_nxt;
	logic [5:0]         ext_prev_a_r, ext_prev_b_r;
	logic [1:0]         spec_r, spec_nxt;
	logic [1:0]         cmd_hit;
	logic [1:0]         rx_spec;

	always_comb
	begin
		cmd_hit[0] = wr_i && (addr_i == OFF_COMMAND_A);
		cmd_hit[1] = wr_i && (addr_i == OFF_COMMAND_B);
		rx_spec    = rx_special_i | (rx_parity_i
			& {mode_b_r[ID_PAR_SP], mode_a_r[ID_PAR_SP]});       // R12
		spec_nxt = spec_r | rx_spec;
		for (int c = 0; c < 2; c++)
			if (cmd_hit[c] && wdata_i == CMD_ERR_RESET && !rx_spec[c])
				spec_nxt[c] = 1'b0;
		// Transmit buffer full tracking, pend on full to empty only
		tx_full_nxt = (tx_full_r | tx_load_i) & ~tx_empty_i;     // R13
		// Master enable gates the chain only, so polling still sees pending
		src_en = {mode_b_r[ID_EXT_IE], mode_b_r[ID_TX_IE],
			mode_b_r[ID_RX_IE], mode_a_r[ID_EXT_IE], mode_a_r[ID_TX_IE],
			mode_a_r[ID_RX_IE]};
		src_set[SRC_A_RX]  = rx_char_i[0] | rx_spec[0];          // R12
		src_set[SRC_B_RX]  = rx_char_i[1] | rx_spec[1];          // R12
		src_set[SRC_A_TX]  = tx_full_r[0] & tx_empty_i[0];       // R13
		src_set[SRC_B_TX]  = tx_full_r[1] & tx_empty_i[1];       // R13
		src_set[SRC_A_EXT] = |((ext_stat_a_i ^ ext_prev_a_r)
			& exten_a_r[7:2]);                                   // R14
		src_set[SRC_B_EXT] = |((ext_stat_b_i ^ ext_prev_b_r)
			& exten_b_r[7:2]);                                   // R14
		src_clr[SRC_A_RX]  = rx_pop_i[0] & ~spec_r[0];           // R5
		src_clr[SRC_B_RX]  = rx_pop_i[1] & ~spec_r[1];           // R5
		src_clr[SRC_A_TX]  = tx_load_i[0] |
			(cmd_hit[0] && wdata_i == CMD_RST_TX_IP);            // R5
		src_clr[SRC_B_TX]  = tx_load_i[1] |
			(cmd_hit[1] && wdata_i == CMD_RST_TX_IP);            // R5
		src_clr[SRC_A_EXT] = cmd_hit[0] && wdata_i == CMD_RST_EXT;
		src_clr[SRC_B_EXT] = cmd_hit[1] && wdata_i == CMD_RST_EXT;
	end

	always_ff @(posedge sys_clk_i)
	begin
		if (rst)
		begin
			tx_full_r    <= 2'h0;
			spec_r       <= 2'h0;
			ext_prev_a_r <= 6'h00;
			ext_prev_b_r <= 6'h00;
		end
		else
		begin
			tx_full_r    <= tx_full_nxt;
			spec_r       <= spec_nxt;
			ext_prev_a_r <= ext_stat_a_i;
			ext_prev_b_r <= ext_stat_b_i;
		end
	end

	// ****************************************************************
	// Source cells and internal chain
	// ****************************************************************
	logic [NUM_SRC-1:0] pend, svc, grant, svc_clr;
	logic [NUM_SRC:0]   chain;    // chain[i] high: nothing above masks i
	logic [NUM_SRC:0]   svc_above; // Some service bit above i
	logic               chain_in;
	logic               rst_ius;

	// Master enable low acts as a low priority-in
	assign chain_in = pin_ok_r & mc_r[MC_MIE];                   // R19
	assign rst_ius  = (cmd_hit[0] | cmd_hit[1]) &&
		wdata_i == CMD_RST_HI_IUS;                               // R11

	for (genvar i = 0; i < NUM_SRC; i++)
	begin : g_src
		// Fixed order: index 0 highest
		assign chain[i+1] = chain[i] & ~svc[i]
			& ~(ack_on_r & pend[i]);                              // R17 R18
		assign svc_above[i+1] = svc_above[i] | svc[i];
		assign svc_clr[i] = rst_ius & svc[i] & ~svc_above[i];   // R11
		dsi_src_cell u_cell
		(
			.sys_clk_i (sys_clk_i),
			.srst_i    (rst),
			.enable_i  (src_en[i]),
			.set_i     (src_set[i]),
			.clr_i     (src_clr[i]),
			.grant_i   (grant[i]),
			.svc_clr_i (svc_clr[i]),
			.pending_o (pend[i]),
			.service_o (svc[i])
		);
	end
	assign chain[0] = chain_in;
	assign svc_above[0] = 1'b0;

	// ****************************************************************
	// Acknowledge sequencing
	// ****************************************************************
	typedef enum logic [1:0] {ACK_IDLE, ACK_SETTLE, ACK_DONE} dsi_ack_e;
	dsi_ack_e           ack_st_r, ack_st_nxt;
	logic [7:0]         settle_r, settle_nxt;
	logic [NUM_SRC-1:0] win;

	always_comb
	begin
		for (int k = 0; k < NUM_SRC; k++)
			win[k] = chain[k] & pend[k] & ~svc[k] & src_en[k];   // R6
		grant      = '0;
		ack_st_nxt = ack_st_r;
		settle_nxt = settle_r;
		case (ack_st_r)
			ACK_IDLE:
				if (ack_on_r)
				begin
					ack_st_nxt = ACK_SETTLE;
					settle_nxt = 8'(SETTLE - 1);
				end
			ACK_SETTLE:
				if (!ack_on_r)
					ack_st_nxt = ACK_IDLE;
				else if (settle_r == 8'h00)
				begin
					grant      = win;                            // R6
					ack_st_nxt = ACK_DONE;
				end
				else
					settle_nxt = settle_r - 8'h01;
			ACK_DONE:
				if (!ack_on_r)
					ack_st_nxt = ACK_IDLE;
			default: ack_st_nxt = ACK_IDLE;
		endcase
	end

	always_ff @(posedge sys_clk_i)
	begin
		if (rst)
		begin
			ack_st_r <= ACK_IDLE;
			settle_r <= 8'h00;
		end
		else
		begin
			ack_st_r <= ack_st_nxt;
			settle_r <= settle_nxt;
		end
	end

	// ****************************************************************
	// Vector encoding, outputs and read mux
	// ****************************************************************
	logic [2:0] code;
	logic [7:0] vec_stat, vec_ack, rdata_nxt;
	logic       req_nxt, pout_nxt, vdrv_nxt;
	logic [NUM_SRC-1:0] top;

	always_comb
	begin
		top  = pend | svc;
		code = 3'h0;
		for (int k = NUM_SRC - 1; k >= 0; k--)
			if (top[k])
				case (k)
					SRC_A_RX:  code = spec_r[0] ? 3'h7 : 3'h6;   // R10
					SRC_A_TX:  code = 3'h4;                      // R10
					SRC_A_EXT: code = 3'h5;                      // R10
					SRC_B_RX:  code = spec_r[1] ? 3'h3 : 3'h2;   // R10
					SRC_B_TX:  code = 3'h0;                      // R10
					default:   code = 3'h1;                      // R10
				endcase
		vec_stat = vbase_r;
		if (mc_r[MC_STHI])
			vec_stat[6:4] = {code[0], code[1], code[2]};        // R9 R10
		else
			vec_stat[3:1] = code;                               // R9 R10
		vec_ack  = mc_r[MC_VIS] ? vec_stat : vbase_r;           // R8
		vdrv_nxt = ack_on_r && ack_st_r == ACK_DONE
			&& !mc_r[MC_NV];                                    // R7
		req_nxt  = |(pend & src_en & {chain[NUM_SRC-1:0]})
			&& !ack_on_r;                                        // R20 R5
		pout_nxt = ack_on_r ? (pin_ok_r & ~(|(pend | svc)))      // R21
			: (pin_ok_r & ~(|svc));
		if (mc_r[MC_DLC])
			pout_nxt = 1'b0;                                     // R22
		rdata_nxt = 8'h00;
		if (rd_i)
			case (addr_i)
				OFF_VECTOR_B:  rdata_nxt = vec_stat;            // R2 R3 R4
				OFF_VECTOR_A:  rdata_nxt = vbase_r;
				OFF_PENDING_A: rdata_nxt = {2'b00, pend[0], pend[1],
					pend[2], pend[3], pend[4], pend[5]};          // R16
				OFF_PRIMARY_A: rdata_nxt = {2'b00, ext_stat_a_i[5:3],
					~tx_full_r[0], 1'b0, rx_char_i[0]};
				OFF_PRIMARY_B: rdata_nxt = {2'b00, ext_stat_b_i[5:3],
					~tx_full_r[1], 1'b0, rx_char_i[1]};
				OFF_SPECIAL_RX_A: rdata_nxt = {7'h00, spec_r[0]};
				OFF_SPECIAL_RX_B: rdata_nxt = {7'h00, spec_r[1]};
				default:       rdata_nxt = 8'h00;
			endcase
	end

	always_ff @(posedge sys_clk_i)
	begin
		if (srst_i)
		begin
			rdata_o         <= 8'h00;
			irq_req_o       <= 1'b0;
			irq_req_oe_n_o  <= 1'b1;
			priority_out_o  <= 1'b0;
			ack_data_o      <= 8'h00;
			ack_data_oe_n_o <= 1'b1;
			error_reset_o   <= 2'h0;
		end
		else
		begin
			rdata_o         <= rdata_nxt;
			irq_req_o       <= 1'b0;
			irq_req_oe_n_o  <= ~req_nxt;
			priority_out_o  <= pout_nxt;
			ack_data_o      <= vec_ack;
			ack_data_oe_n_o <= ~vdrv_nxt;
			error_reset_o   <= {cmd_hit[1] && wdata_i == CMD_ERR_RESET,
				cmd_hit[0] && wdata_i == CMD_ERR_RESET};
		end
	end

endmodule : dsi_irq_chain

`default_nettype wire

// >>> testbench/dsi_irq_asserts.sv
// Port checker for the interrupt daisy chain block.
// Assumes it is bound to dsi_irq_chain and sees only its ports.
`default_nettype none

module dsi_irq_asserts
(
	input wire logic       sys_clk_i,           // Clock
	input wire logic       srst_i,              // Sync reset
	input wire logic       priority_in_i,       // Chain in
	input wire logic       irq_acknowledge_n_i, // Acknowledge
	input wire logic       priority_out_o,      // Chain out
	input wire logic       irq_req_o,           // Request level
	input wire logic       irq_req_oe_n_o,      // Request pull
	input wire logic [7:0] ack_data_o,          // Vector
	input wire logic       ack_data_oe_n_o      // Vector drive
);
	// ****************************************************************
	// Properties
	// ****************************************************************
	// Eight cycles cover the pin synchroniser plus the output register
	default clocking cb @(posedge sys_clk_i); endclocking
	default disable iff (srst_i);

	chk_pin_low_quiet: assert property
		((!priority_in_i) [*8] |-> irq_req_oe_n_o)
		else $error("request pulled with priority in low");
	chk_ack_no_req: assert property
		((!irq_acknowledge_n_i) [*8] |-> irq_req_oe_n_o)
		else $error("request pulled during acknowledge");
	chk_req_level_low: assert property
		(irq_req_o == 1'b0)
		else $error("request line driven high");
	chk_vec_blocks_out: assert property
		(!ack_data_oe_n_o |-> !priority_out_o)
		else $error("priority out high while vector driven");
	chk_out_follows_in: assert property
		((!priority_in_i) [*8] |-> !priority_out_o)
		else $error("priority out high with priority in low");
	chk_vec_in_ack: assert property
		($fell(ack_data_oe_n_o) |-> !irq_acknowledge_n_i)
		else $error("vector driven outside acknowledge");
	chk_vec_release: assert property
		($rose(irq_acknowledge_n_i) |-> ##[0:10] ack_data_oe_n_o)
		else $error("vector still driven after acknowledge");
	chk_vec_held: assert property
		(!ack_data_oe_n_o && !$past(ack_data_oe_n_o)
			|-> $stable(ack_data_o))
		else $error("vector changed while driven");
endmodule : dsi_irq_asserts

bind dsi_irq_chain dsi_irq_asserts u_dsi_irq_asserts
(
	.sys_clk_i          (sys_clk_i),
	.srst_i             (srst_i),
	.priority_in_i      (priority_in_i),
	.irq_acknowledge_n_i(irq_acknowledge_n_i),
	.priority_out_o     (priority_out_o),
	.irq_req_o          (irq_req_o),
	.irq_req_oe_n_o     (irq_req_oe_n_o),
	.ack_data_o         (ack_data_o),
	.ack_data_oe_n_o    (ack_data_oe_n_o)
);

`default_nettype wire

// >>> testbench/dsi_host_model.sv
// Host processor and outer chain seen from the block's pins.
// Assumes a pull-up on the request line and a floating data bus.
`default_nettype none

module dsi_host_model
(
	input  wire logic       sys_clk_i,          // Clock
	input  wire logic       irq_req_i,          // Request level
	input  wire logic       irq_req_oe_n_i,     // Request pull
	input  wire logic [7:0] ack_data_i,         // Vector
	input  wire logic       ack_data_oe_n_i,    // Vector drive
	output var  logic       priority_in_o,      // Chain in
	output var  logic       irq_acknowledge_n_o,// Acknowledge
	output wire logic       irq_line_o,         // Resolved line
	output wire logic [7:0] data_bus_o          // Resolved bus
);
	timeunit 1ns;
	timeprecision 1ns;

	logic [7:0] last_r = 8'h00;

	initial
	begin
		priority_in_o = 1'b1;
		irq_acknowledge_n_o = 1'b1;
	end

	assign irq_line_o = irq_req_oe_n_i ? 1'b1 : irq_req_i;
	// Undriven bus shows the inverse so stale data never matches
	assign data_bus_o = ack_data_oe_n_i ? ~last_r : ack_data_i;

	always @(posedge sys_clk_i)
		if (!ack_data_oe_n_i)
			last_r <= ack_data_i;

	task automatic set_pin(logic v);
		@(posedge sys_clk_i);
		priority_in_o <= v;
	endtask : set_pin

	// Acknowledge once the request is seen or after 20 cycles without it
	task automatic ack_cycle(output logic [7:0] vec,
		output logic drove);
		drove = 1'b0;
		vec = 8'h00;
		for (int n = 0; n < 20 && irq_line_o; n++)
			@(posedge sys_clk_i);
		irq_acknowledge_n_o <= 1'b0;
		repeat (30)
		begin
			@(negedge sys_clk_i);
			if (ack_data_oe_n_i === 1'b0 && !drove)
			begin
				drove = 1'b1;
				vec = data_bus_o;
			end
		end
		irq_acknowledge_n_o <= 1'b1;
		repeat (10) @(posedge sys_clk_i);
	endtask : ack_cycle
endmodule : dsi_host_model

`default_nettype wire

// >>> testbench/dsi_irq_chain_bench.sv
// Self-checking bench for the interrupt daisy chain block.
// Assumes the host model and the bound checker are compiled first.
`default_nettype none

module dsi_irq_chain_bench;
	timeunit 1ns;
	timeprecision 1ns;
	import dsi_pkg::*;

	logic       sys_clk_i = 1'b0;
	logic       srst_i = 1'b1;
	logic [3:0] addr_i = 4'h0;
	logic [7:0] wdata_i = 8'h00;
	logic       wr_i = 1'b0;
	logic       rd_i = 1'b0;
	logic [1:0] rx_char_i = 2'h0;
	logic [1:0] rx_spec_i = 2'h0;
	logic [1:0] rx_par_i = 2'h0;
	logic [1:0] rx_pop_i = 2'h0;
	logic [1:0] tx_empty_i = 2'h3;
	logic [1:0] tx_load_i = 2'h0;
	logic [5:0] ext_b_i = 6'h00;
	wire  [7:0] rdata, ack_data, bus;
	wire        pout, req, req_oe_n, ack_oe_n, pin, ack_n, line;
	wire  [1:0] err_rst;
	int         fails = 0;
	int         comparisons = 0;
	int         cyc = 0;
	logic [7:0] v, b;
	logic       drv, hi;

	dsi_irq_chain u_dsi_irq_chain (.sys_clk_i(sys_clk_i), .srst_i(srst_i),
		.addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i),
		.rdata_o(rdata), .rx_char_i(rx_char_i), .rx_special_i(rx_spec_i),
		.rx_parity_i(rx_par_i), .rx_pop_i(rx_pop_i), .tx_empty_i(tx_empty_i),
		.tx_load_i(tx_load_i), .ext_stat_a_i(6'h00), .ext_stat_b_i(ext_b_i),
		.priority_in_i(pin), .irq_acknowledge_n_i(ack_n),
		.priority_out_o(pout), .irq_req_o(req), .irq_req_oe_n_o(req_oe_n),
		.ack_data_o(ack_data), .ack_data_oe_n_o(ack_oe_n),
		.error_reset_o(err_rst));
	dsi_host_model u_dsi_host_model (.sys_clk_i(sys_clk_i),
		.irq_req_i(req), .irq_req_oe_n_i(req_oe_n), .ack_data_i(ack_data),
		.ack_data_oe_n_i(ack_oe_n), .priority_in_o(pin),
		.irq_acknowledge_n_o(ack_n), .irq_line_o(line), .data_bus_o(bus));

	initial
		forever #25 sys_clk_i = ~sys_clk_i;

	// ****************************************************************
	// Bus tasks and expectations
	// ****************************************************************
	task automatic tick(int n);
		repeat (n) @(posedge sys_clk_i);
	endtask : tick

	task automatic wr(logic [3:0] a, logic [7:0] d);
		@(posedge sys_clk_i);
		addr_i <= a;
		wdata_i <= d;
		wr_i <= 1'b1;
		@(posedge sys_clk_i);
		wr_i <= 1'b0;
	endtask : wr

	task automatic chk(string nm, logic [7:0] e, logic [7:0] g);
		comparisons++;
		if (g !== e)
		begin
			fails++;
			$display("FAIL %s expected %h seen %h", nm, e, g);
		end
	endtask : chk

	// Read data stand only in the cycle after the strobe
	task automatic rchk(string nm, logic [3:0] a, logic [7:0] e);
		@(posedge sys_clk_i);
		addr_i <= a;
		rd_i <= 1'b1;
		@(posedge sys_clk_i);
		rd_i <= 1'b0;
		#1 chk(nm, e, rdata);
	endtask : rchk

	function automatic logic [7:0] vec_exp(logic [7:0] base,
		logic [2:0] c, logic h);
		vec_exp = base;
		if (h)
			vec_exp[6:4] = {c[0], c[1], c[2]};
		else
			vec_exp[3:1] = c;
	endfunction : vec_exp

	task automatic print_verdict();
		$display("comparisons %0d fails %0d", comparisons, fails);
		if (fails == 0 && comparisons > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask : print_verdict

	always @(posedge sys_clk_i)
	begin
		cyc <= cyc + 1;
		if (cyc == 20000)
		begin
			fails++;
			print_verdict();
		end
	end

	// ****************************************************************
	// Scenarios
	// ****************************************************************
	initial
	begin
		void'($urandom(68459));
		tick(5);
		srst_i <= 1'b0;
		tick(4);
		rchk("unmapped", 4'hf, 8'h00);
		wr(OFF_VECTOR_BASE, 8'h5a);
		wr(OFF_IRQ_DMA_B, 8'h02);
		wr(OFF_MASTER_CTRL, 8'h08);
		rx_char_i <= 2'b10;
		tick(1);
		rx_char_i <= 2'b00;
		tick(4);
		rchk("pending idle", OFF_PENDING_A, 8'h00);
		tx_load_i <= 2'b10;
		tx_empty_i <= 2'b01;
		tick(1);
		tx_load_i <= 2'b00;
		tick(2);
		tx_empty_i <= 2'b11;
		tick(4);
		rchk("pending txb", OFF_PENDING_A, 8'h02);
		wr(OFF_PENDING_A, 8'hff);
		rchk("pending ro", OFF_PENDING_A, 8'h02);
		rchk("vector txb", OFF_VECTOR_B, vec_exp(8'h5a, 3'd0, 1'b0));
		tick(6);
		chk("line on", 8'h00, {7'h0, line});
		u_dsi_host_model.set_pin(1'b0);
		tick(8);
		chk("line pin low", 8'h01, {7'h0, line});
		u_dsi_host_model.set_pin(1'b1);
		wr(OFF_MASTER_CTRL, 8'h00);
		tick(8);
		chk("line mie off", 8'h01, {7'h0, line});
		rchk("poll pending", OFF_PENDING_A, 8'h02);
		wr(OFF_IRQ_DMA_A, 8'h08);
		rx_char_i <= 2'b01;
		tick(1);
		rx_char_i <= 2'b00;
		tick(4);
		rchk("pending two", OFF_PENDING_A, 8'h22);
		rchk("vector rxa", OFF_VECTOR_B, vec_exp(8'h5a, 3'd6, 1'b0));
		wr(OFF_MASTER_CTRL, 8'h19);
		u_dsi_host_model.ack_cycle(v, drv);
		chk("ack drove", 8'h01, {7'h0, drv});
		chk("ack vec hi", vec_exp(8'h5a, 3'd6, 1'b1), v);
		rx_pop_i <= 2'b01;
		tick(1);
		rx_pop_i <= 2'b00;
		tick(4);
		rchk("pending pop", OFF_PENDING_A, 8'h02);
		tick(6);
		chk("line masked", 8'h01, {7'h0, line});
		wr(OFF_COMMAND_A, CMD_RST_HI_IUS);
		tick(8);
		chk("line unmasked", 8'h00, {7'h0, line});
		wr(OFF_MASTER_CTRL, 8'h0a);
		u_dsi_host_model.ack_cycle(v, drv);
		chk("nv no drive", 8'h00, {7'h0, drv});
		tx_load_i <= 2'b10;
		tx_empty_i <= 2'b01;
		tick(1);
		tx_load_i <= 2'b00;
		tick(8);
		chk("line clear", 8'h01, {7'h0, line});
		rx_char_i <= 2'b01;
		tick(1);
		rx_char_i <= 2'b00;
		u_dsi_host_model.ack_cycle(v, drv);
		rx_pop_i <= 2'b01;
		tick(1);
		rx_pop_i <= 2'b00;
		wr(OFF_COMMAND_A, CMD_RST_HI_IUS);
		tick(8);
		chk("out nested", 8'h00, {7'h0, pout});
		wr(OFF_COMMAND_A, CMD_RST_HI_IUS);
		wr(OFF_MASTER_CTRL, 8'h04);
		tick(8);
		chk("out dlc", 8'h00, {7'h0, pout});
		wr(OFF_MASTER_CTRL, 8'h08);
		tick(8);
		chk("out follows", 8'h01, {7'h0, pout});
		wr(OFF_IRQ_DMA_B, 8'h01);
		wr(OFF_EXT_EN_B, 8'h00);
		ext_b_i <= 6'h3f;
		tick(4);
		rchk("ext masked", OFF_PENDING_A, 8'h00);
		wr(OFF_EXT_EN_B, 8'hfc);
		ext_b_i[$urandom_range(5, 0)] <= 1'b0;
		tick(4);
		rchk("ext pending", OFF_PENDING_A, 8'h01);
		for (int i = 0; i < 16; i++)
		begin
			b = 8'($urandom);
			hi = 1'($urandom);
			wr(OFF_VECTOR_BASE, b);
			wr(OFF_MASTER_CTRL, {3'b000, hi, 3'b100, 1'($urandom)});
			rchk("vector ext", OFF_VECTOR_B, vec_exp(b, 3'd1, hi));
		end
		wr(OFF_MASTER_CTRL, 8'h08);
		u_dsi_host_model.ack_cycle(v, drv);
		chk("ack plain", b, v);
		wr(OFF_COMMAND_B, CMD_RST_EXT);
		wr(OFF_COMMAND_A, CMD_RST_HI_IUS);
		tick(2);
		rchk("ext cleared", OFF_PENDING_A, 8'h00);
		wr(OFF_IRQ_DMA_B, 8'h08);
		rx_par_i <= 2'b10;
		tick(1);
		rx_par_i <= 2'b00;
		tick(4);
		rchk("parity off", OFF_PENDING_A, 8'h00);
		rx_spec_i <= 2'b10;
		tick(1);
		rx_spec_i <= 2'b00;
		tick(4);
		rchk("pending rxb", OFF_PENDING_A, 8'h04);
		rchk("vector spec", OFF_VECTOR_B, vec_exp(b, 3'd3, 1'b0));
		wr(OFF_COMMAND_B, CMD_ERR_RESET);
		#1 chk("err pulse", 8'h02, {6'h0, err_rst});
		print_verdict();
	end
endmodule : dsi_irq_chain_bench

`default_nettype wire
